// [logic/drsf_pkg.sv]
// Constants and carrier types for the DMA request selection and transfer flow block
`default_nettype none
package drsf_pkg;
  // Register offsets (byte addresses, low address byte)
  localparam logic [7:0] OFS_OPERATION_CONTROL = 8'h00;
  localparam logic [7:0] OFS_SELECTOR_CH01 = 8'h04;
  localparam logic [7:0] OFS_SELECTOR_CH23 = 8'h08;
  localparam logic [1:0] CH_REGION = 2'h1;
  localparam logic [3:0] OFS_CH_CONTROL = 4'h0;
  localparam logic [3:0] OFS_CH_COUNT = 4'h4;
  localparam logic [3:0] OFS_CH_INIT_COUNT = 4'h8;
  // Reset values
  localparam logic [15:0] SELECTOR_RESET = 16'h0000;
  localparam logic [1:0] PRIORITY_RESET = 2'h0;
  localparam logic [1:0] RR_LAST_RESET = 2'h3;
  // Operation control fields
  localparam int OPC_MASTER_EN = 0;
  localparam int OPC_NMI_FLAG = 1;
  localparam int OPC_ADDR_ERR = 2;
  localparam int OPC_PRIO_LSB = 8;
  // Channel control fields
  localparam int CC_ENABLE = 0;
  localparam int CC_END_FLAG = 1;
  localparam int CC_DONE_IE = 2;
  localparam int CC_HALF_IE = 3;
  localparam int CC_LEVEL_POL = 4;
  localparam int CC_EDGE_SEL = 5;
  localparam int CC_OVERRUN = 6;
  localparam int CC_SIZE_LSB = 8;
  localparam int CC_RS_LSB = 12;
  // Selector byte layout per channel
  localparam int SEL_CH_W = 8;
  // Priority codes
  localparam logic [1:0] PRIO_FIXED1 = 2'h0;
  localparam logic [1:0] PRIO_FIXED2 = 2'h1;
  localparam logic [1:0] PRIO_ROUND_ROBIN = 2'h3;
  // Request source codes
  localparam logic [3:0] RS_EXT_DUAL = 4'h0;
  localparam logic [3:0] RS_EXT_MEM_TO_DEV = 4'h2;
  localparam logic [3:0] RS_EXT_DEV_TO_MEM = 4'h3;
  localparam logic [3:0] RS_AUTO = 4'h4;
  localparam logic [3:0] RS_PERIPH = 4'h8;

  typedef enum logic [2:0] {
    ADDR_DUAL = 3'b001,
    ADDR_MEM_TO_DEV = 3'b010,
    ADDR_DEV_TO_MEM = 3'b100
  } drsf_amode_e;

  typedef struct packed {
    logic valid;
    logic [1:0] channel;
    logic [1:0] unitSize;
    drsf_amode_e addrMode;
  } drsf_xfer_s;
endpackage : drsf_pkg
`default_nettype wire

// [logic/drsf_dma_request_select_flow.sv]
// Four-channel DMA request selection, arbitration and transfer-count flow
// Operation
// - Two 16-bit selectors: one for channels 0/1, one for channels 2/3.
// - Upper byte: upper channel module code and kind; lower byte: lower channel.
// - Selectors reset to zero and hold contents otherwise.
// - Module code plus kind, eight bits, picks one peripheral request line.
// - Peripheral requests count only when request source field is 1000.
// - Enabled needs channel and master enable, no end, error or NMI flag.
// - Each accepted request moves one unit and decrements the count once.
// - Auto-request transfers start as soon as the channel is enabled.
// - Half-count interrupt when count reaches half its initial value, if enabled.
// - Count reaching zero ends the channel and raises completion interrupt if enabled.
// - Address error, NMI, or clearing either enable terminates transfers.
// - Two external request inputs, one per channel 0 and 1.
// - Source code 0000 dual, 0010 memory to device, 0011 device to memory.
// - Detection: 00 low, 01 falling, 10 high, 11 rising.
// - Request input ignored from acceptance until its acknowledge is issued.
// - Level mode overrun bit: 0 stop at request count, 1 one extra transfer.
// - Requester need not be source or destination; addresses unconstrained.
// - Error and NMI flags set on events; cleared by writing 0 after reading 1.
// - Priority 00: 0>1>2>3, 01: 0>2>3>1, 11: round-robin.
`default_nettype none
module drsf_dma_request_select_flow #(
  parameter int COUNT_W = 24,
  parameter int PERIPH_N = 256
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [PERIPH_N-1:0] periphReq,
  output logic [PERIPH_N-1:0] periphAck,
  input wire logic [1:0] extRequest,
  output logic [1:0] extAcknowledge,
  input wire logic nmiEvent,
  input wire logic addrErrorEvent,
  output drsf_pkg::drsf_xfer_s xfer,
  output logic [3:0] halfCountIrq,
  output logic [3:0] completionIrq
);
  // Bus state
  logic wrPend;
  logic [7:0] wrAddr;
  logic addrPhase;
  logic [31:0] readMux;
  // Shared control
  logic [15:0] requestSelectorCh01;
  logic [15:0] requestSelectorCh23;
  logic masterEnable;
  logic nmiStopFlag;
  logic addressErrorFlag;
  logic nmiArmed;
  logic aeArmed;
  logic [1:0] prioritySelect;
  logic [1:0] rrLast;
  // Per-channel control
  logic [3:0] channelEnable;
  logic [3:0] transferEndFlag;
  logic [3:0] teArmed;
  logic [3:0] completionIrqEnable;
  logic [3:0] halfIrqEnable;
  logic [3:0] levelPolaritySelect;
  logic [3:0] edgeSelect;
  logic [3:0] overrunSelect;
  logic [1:0] unitSize [4];
  logic [3:0] requestSourceField [4];
  logic [COUNT_W-1:0] transferCount [4];
  logic [COUNT_W-1:0] initCount [4];
  logic [3:0] halfDone;
  // Request path
  logic [1:0] extSync1;
  logic [1:0] extSync2;
  logic [1:0] extPrev;
  logic [3:0] pend;
  logic [3:0] blocked;
  logic [3:0] ackIssued;
  logic [3:0] ackHold;
  logic [3:0] ackHold2;
  logic [3:0] chanOn;
  logic [3:0] rawReq;
  logic [3:0] accept;
  logic grantValid;
  logic [1:0] grantCh;
  logic [7:0] chanCode [4];
  logic wrOp;
  logic rdOp;
  logic [3:0] wrCtrl;
  logic [3:0] wrCount;

  assign addrPhase = hsel & htrans[1] & hready;
  assign wrOp = wrPend & (wrAddr == drsf_pkg::OFS_OPERATION_CONTROL);
  assign rdOp = addrPhase & ~hwrite & (haddr[7:0] == drsf_pkg::OFS_OPERATION_CONTROL);

  always_comb begin
    chanCode[0] = requestSelectorCh01[7:0];
    chanCode[1] = requestSelectorCh01[15:8];
    chanCode[2] = requestSelectorCh23[7:0];
    chanCode[3] = requestSelectorCh23[15:8];
    for (int c = 0; c < 4; c++) begin
      wrCtrl[c] = wrPend && wrAddr[7:6] == drsf_pkg::CH_REGION && wrAddr[5:4] == 2'(c)
        && wrAddr[3:0] == drsf_pkg::OFS_CH_CONTROL;
      wrCount[c] = wrPend && wrAddr[7:6] == drsf_pkg::CH_REGION && wrAddr[5:4] == 2'(c)
        && wrAddr[3:0] == drsf_pkg::OFS_CH_COUNT;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend <= addrPhase & hwrite;
      wrAddr <= haddr[7:0];
      if (addrPhase & ~hwrite) begin
        hrdata <= readMux;
      end
    end
  end

  always_comb begin
    readMux = 32'h0000_0000;
    if (haddr[7:0] == drsf_pkg::OFS_OPERATION_CONTROL) begin
      readMux[drsf_pkg::OPC_MASTER_EN] = masterEnable;
      readMux[drsf_pkg::OPC_NMI_FLAG] = nmiStopFlag;
      readMux[drsf_pkg::OPC_ADDR_ERR] = addressErrorFlag;
      readMux[drsf_pkg::OPC_PRIO_LSB +: 2] = prioritySelect;
    end else if (haddr[7:0] == drsf_pkg::OFS_SELECTOR_CH01) begin
      readMux[15:0] = requestSelectorCh01;
    end else if (haddr[7:0] == drsf_pkg::OFS_SELECTOR_CH23) begin
      readMux[15:0] = requestSelectorCh23;
    end else if (haddr[7:6] == drsf_pkg::CH_REGION) begin
      if (haddr[3:0] == drsf_pkg::OFS_CH_CONTROL) begin
        readMux[drsf_pkg::CC_ENABLE] = channelEnable[haddr[5:4]];
        readMux[drsf_pkg::CC_END_FLAG] = transferEndFlag[haddr[5:4]];
        readMux[drsf_pkg::CC_DONE_IE] = completionIrqEnable[haddr[5:4]];
        readMux[drsf_pkg::CC_HALF_IE] = halfIrqEnable[haddr[5:4]];
        readMux[drsf_pkg::CC_LEVEL_POL] = levelPolaritySelect[haddr[5:4]];
        readMux[drsf_pkg::CC_EDGE_SEL] = edgeSelect[haddr[5:4]];
        readMux[drsf_pkg::CC_OVERRUN] = overrunSelect[haddr[5:4]];
        readMux[drsf_pkg::CC_SIZE_LSB +: 2] = unitSize[haddr[5:4]];
        readMux[drsf_pkg::CC_RS_LSB +: 4] = requestSourceField[haddr[5:4]];
      end else if (haddr[3:0] == drsf_pkg::OFS_CH_COUNT) begin
        readMux[COUNT_W-1:0] = transferCount[haddr[5:4]];
      end else if (haddr[3:0] == drsf_pkg::OFS_CH_INIT_COUNT) begin
        readMux[COUNT_W-1:0] = initCount[haddr[5:4]];
      end
    end
  end

  // Selectors keep contents until rewritten
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      requestSelectorCh01 <= drsf_pkg::SELECTOR_RESET;
      requestSelectorCh23 <= drsf_pkg::SELECTOR_RESET;
    end else if (wrPend) begin
      if (wrAddr == drsf_pkg::OFS_SELECTOR_CH01) begin
        requestSelectorCh01 <= hwdata[15:0];
      end
      if (wrAddr == drsf_pkg::OFS_SELECTOR_CH23) begin
        requestSelectorCh23 <= hwdata[15:0];
      end
    end
  end

  // Operation control; event set wins over a clearing write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      masterEnable <= 1'b0;
      nmiStopFlag <= 1'b0;
      addressErrorFlag <= 1'b0;
      nmiArmed <= 1'b0;
      aeArmed <= 1'b0;
      prioritySelect <= drsf_pkg::PRIORITY_RESET;
    end else begin
      if (wrOp) begin
        masterEnable <= hwdata[drsf_pkg::OPC_MASTER_EN];
        prioritySelect <= hwdata[drsf_pkg::OPC_PRIO_LSB +: 2];
        nmiArmed <= 1'b0;
        aeArmed <= 1'b0;
      end
      if (rdOp & nmiStopFlag) begin
        nmiArmed <= 1'b1;
      end
      if (rdOp & addressErrorFlag) begin
        aeArmed <= 1'b1;
      end
      if (nmiEvent) begin
        nmiStopFlag <= 1'b1;
      end else if (wrOp & nmiArmed & ~hwdata[drsf_pkg::OPC_NMI_FLAG]) begin
        nmiStopFlag <= 1'b0;
      end
      if (addrErrorEvent) begin
        addressErrorFlag <= 1'b1;
      end else if (wrOp & aeArmed & ~hwdata[drsf_pkg::OPC_ADDR_ERR]) begin
        addressErrorFlag <= 1'b0;
      end
    end
  end

  // Channel control; end flag follows the same read-then-write-0 clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      channelEnable <= 4'h0;
      transferEndFlag <= 4'h0;
      teArmed <= 4'h0;
      completionIrqEnable <= 4'h0;
      halfIrqEnable <= 4'h0;
      levelPolaritySelect <= 4'h0;
      edgeSelect <= 4'h0;
      overrunSelect <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        unitSize[c] <= 2'h0;
        requestSourceField[c] <= 4'h0;
      end
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (wrCtrl[c]) begin
          channelEnable[c] <= hwdata[drsf_pkg::CC_ENABLE];
          completionIrqEnable[c] <= hwdata[drsf_pkg::CC_DONE_IE];
          halfIrqEnable[c] <= hwdata[drsf_pkg::CC_HALF_IE];
          levelPolaritySelect[c] <= hwdata[drsf_pkg::CC_LEVEL_POL];
          edgeSelect[c] <= hwdata[drsf_pkg::CC_EDGE_SEL];
          overrunSelect[c] <= hwdata[drsf_pkg::CC_OVERRUN];
          unitSize[c] <= hwdata[drsf_pkg::CC_SIZE_LSB +: 2];
          requestSourceField[c] <= hwdata[drsf_pkg::CC_RS_LSB +: 4];
          teArmed[c] <= 1'b0;
        end
        if (addrPhase && !hwrite && haddr[7:6] == drsf_pkg::CH_REGION && haddr[5:4] == 2'(c)
            && haddr[3:0] == drsf_pkg::OFS_CH_CONTROL && transferEndFlag[c]) begin
          teArmed[c] <= 1'b1;
        end
        if (grantValid && grantCh == 2'(c) && transferCount[c] == COUNT_W'(1)) begin
          transferEndFlag[c] <= 1'b1;
        end else if (wrCtrl[c] & teArmed[c] & ~hwdata[drsf_pkg::CC_END_FLAG]) begin
          transferEndFlag[c] <= 1'b0;
        end
      end
    end
  end

  // External request pins pass two flip-flops first
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      extSync1 <= 2'h0;
      extSync2 <= 2'h0;
      extPrev <= 2'h0;
    end else begin
      extSync1 <= extRequest;
      extSync2 <= extSync1;
      extPrev <= extSync2;
    end
  end

  // Request qualification per channel
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      chanOn[c] = channelEnable[c] & masterEnable & ~transferEndFlag[c]
        & ~addressErrorFlag & ~nmiStopFlag;
      rawReq[c] = 1'b0;
      unique case (requestSourceField[c])
        drsf_pkg::RS_PERIPH: rawReq[c] = periphReq[chanCode[c]];
        drsf_pkg::RS_AUTO: rawReq[c] = 1'b1;
        drsf_pkg::RS_EXT_DUAL, drsf_pkg::RS_EXT_MEM_TO_DEV, drsf_pkg::RS_EXT_DEV_TO_MEM: begin
          if (c < 2) begin
            unique case ({levelPolaritySelect[c], edgeSelect[c]})
              2'b00: rawReq[c] = ~extSync2[c[0]];
              2'b01: rawReq[c] = extPrev[c[0]] & ~extSync2[c[0]];
              2'b10: rawReq[c] = extSync2[c[0]];
              2'b11: rawReq[c] = ~extPrev[c[0]] & extSync2[c[0]];
            endcase
          end
        end
        default: rawReq[c] = 1'b0;
      endcase
      accept[c] = chanOn[c] & rawReq[c] & ~pend[c] & ~blocked[c];
    end
  end

  // Arbitration; later loop passes hold higher priority
  always_comb begin
    logic [1:0] idx;
    idx = 2'h0;
    grantValid = 1'b0;
    grantCh = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      unique case (prioritySelect)
        drsf_pkg::PRIO_FIXED2: idx = (k == 0) ? 2'h0 : (k == 1) ? 2'h2 : (k == 2) ? 2'h3 : 2'h1;
        drsf_pkg::PRIO_ROUND_ROBIN: idx = 2'(rrLast + 2'h1 + 2'(k));
        default: idx = 2'(k);
      endcase
      if (pend[idx] & chanOn[idx]) begin
        grantValid = 1'b1;
        grantCh = idx;
      end
    end
  end

  // Pending, non-sensitive period and acknowledges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend <= 4'h0;
      blocked <= 4'h0;
      ackIssued <= 4'h0;
      ackHold <= 4'h0;
      ackHold2 <= 4'h0;
      periphAck <= '0;
      extAcknowledge <= 2'h0;
    end else begin
      periphAck <= '0;
      extAcknowledge <= 2'h0;
      ackIssued <= 4'h0;
      ackHold2 <= ackHold;
      for (int c = 0; c < 4; c++) begin
        ackHold[c] <= ackIssued[c];
        if (accept[c]) begin
          pend[c] <= 1'b1;
          blocked[c] <= 1'b1;
        end else if (grantValid && grantCh == 2'(c)) begin
          pend[c] <= 1'b0;
        end else if (!chanOn[c]) begin
          pend[c] <= 1'b0;
        end
        // Pins resample two flops late; level overrun 1 reopens at the acknowledge
        if (!accept[c] && ((c < 2 && requestSourceField[c] != drsf_pkg::RS_PERIPH
            && requestSourceField[c] != drsf_pkg::RS_AUTO)
            ? ((!edgeSelect[c] && overrunSelect[c]) ? ackIssued[c] : ackHold2[c]) : ackHold[c])) begin
          blocked[c] <= 1'b0;
        end
        if (!chanOn[c] && !pend[c]) begin
          blocked[c] <= 1'b0;
        end
      end
      if (grantValid) begin
        ackIssued[grantCh] <= 1'b1;
        if (requestSourceField[grantCh] == drsf_pkg::RS_PERIPH) begin
          periphAck[chanCode[grantCh]] <= 1'b1;
        end else if (requestSourceField[grantCh] != drsf_pkg::RS_AUTO && !grantCh[1]) begin
          extAcknowledge[grantCh[0]] <= 1'b1;
        end
      end
    end
  end

  // Round-robin pointer; a write that changes the priority restores the reset order
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rrLast <= drsf_pkg::RR_LAST_RESET;
    end else if (wrOp && hwdata[drsf_pkg::OPC_PRIO_LSB +: 2] != prioritySelect) begin
      rrLast <= drsf_pkg::RR_LAST_RESET;
    end else if (grantValid) begin
      rrLast <= grantCh;
    end
  end

  // Transfer issue; requester and endpoints independent
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      xfer <= '0;
    end else begin
      xfer.valid <= grantValid;
      xfer.channel <= grantCh;
      xfer.unitSize <= unitSize[grantCh];
      unique case (requestSourceField[grantCh])
        drsf_pkg::RS_EXT_MEM_TO_DEV: xfer.addrMode <= drsf_pkg::ADDR_MEM_TO_DEV;
        drsf_pkg::RS_EXT_DEV_TO_MEM: xfer.addrMode <= drsf_pkg::ADDR_DEV_TO_MEM;
        default: xfer.addrMode <= drsf_pkg::ADDR_DUAL;
      endcase
    end
  end

  // Counts and interrupts
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      halfCountIrq <= 4'h0;
      completionIrq <= 4'h0;
      halfDone <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        transferCount[c] <= '0;
        initCount[c] <= '0;
      end
    end else begin
      halfCountIrq <= 4'h0;
      completionIrq <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        if (wrCount[c]) begin
          transferCount[c] <= hwdata[COUNT_W-1:0];
          initCount[c] <= hwdata[COUNT_W-1:0];
          halfDone[c] <= 1'b0;
        end else if (grantValid && grantCh == 2'(c)) begin
          transferCount[c] <= transferCount[c] - COUNT_W'(1);
          if (transferCount[c] - COUNT_W'(1) == (initCount[c] >> 1) && !halfDone[c]) begin
            halfDone[c] <= 1'b1;
            halfCountIrq[c] <= halfIrqEnable[c];
          end
          if (transferCount[c] == COUNT_W'(1)) begin
            completionIrq[c] <= completionIrqEnable[c];
          end
        end
      end
    end
  end
endmodule : drsf_dma_request_select_flow
`default_nettype wire

// [dv/drsf_flow_props.sv]
// Port-level checks for the DMA request selection block, bound into it
`default_nettype none
module drsf_flow_props #(
  parameter int PERIPH_N = 256
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [PERIPH_N-1:0] periphReq,
  input wire logic [PERIPH_N-1:0] periphAck,
  input wire logic [1:0] extAcknowledge,
  input wire logic nmiEvent,
  input wire logic addrErrorEvent,
  input wire drsf_pkg::drsf_xfer_s xfer,
  input wire logic [3:0] halfCountIrq,
  input wire logic [3:0] completionIrq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Requester holds its line until it sees the acknowledge
  a_ack_follows_req: assert property ((periphAck & ~$past(periphReq)) == '0)
    else $error("peripheral acknowledge without a request");
  a_ack_with_unit: assert property (|periphAck |-> xfer.valid && $onehot(periphAck))
    else $error("peripheral acknowledge without a unit");
  a_ext_ack_chan: assert property (|extAcknowledge |-> xfer.valid && extAcknowledge == (2'b01 << xfer.channel))
    else $error("external acknowledge on wrong channel");
  a_single_is_ext: assert property (xfer.valid && xfer.addrMode != drsf_pkg::ADDR_DUAL |->
    !xfer.channel[1] && extAcknowledge[xfer.channel[0]])
    else $error("single address unit without external request");
  a_mode_onehot: assert property (xfer.valid |-> $onehot(xfer.addrMode))
    else $error("unit carries no single address mode");
  a_done_on_unit: assert property (|completionIrq |-> xfer.valid && completionIrq == (4'b0001 << xfer.channel))
    else $error("completion pulse not on the final unit");
  a_half_on_unit: assert property (|halfCountIrq |-> xfer.valid && halfCountIrq == (4'b0001 << xfer.channel))
    else $error("half pulse not on a unit");
  a_half_once: assert property (|halfCountIrq |=> (halfCountIrq == 4'h0)[*3])
    else $error("half pulse repeated");
  // A granted unit may still finish
  a_nmi_halts: assert property (nmiEvent |=> ##2 (!xfer.valid)[*8])
    else $error("unit moved after stop event");
  a_aerr_halts: assert property (addrErrorEvent |=> ##2 (!xfer.valid)[*8])
    else $error("unit moved after address error");
endmodule : drsf_flow_props
bind drsf_dma_request_select_flow drsf_flow_props #(.PERIPH_N(PERIPH_N)) drsf_flow_props_inst (
  .core_clk(core_clk), .rst_n(rst_n), .periphReq(periphReq), .periphAck(periphAck),
  .extAcknowledge(extAcknowledge), .nmiEvent(nmiEvent), .addrErrorEvent(addrErrorEvent), .xfer(xfer),
  .halfCountIrq(halfCountIrq), .completionIrq(completionIrq));
`default_nettype wire

// [dv/drsf_req_model.sv]
// Peripheral and external requester model
`default_nettype none
module drsf_req_model #(
  parameter int PERIPH_N = 256
) (
  input wire logic core_clk,
  input wire logic [PERIPH_N-1:0] periphAck,
  input wire logic [1:0] extAcknowledge,
  output logic [PERIPH_N-1:0] periphReq,
  output logic [1:0] extRequest
);
  timeunit 1ns;
  timeprecision 1ps;
  int misses = 0;
  initial begin
    periphReq = '0;
    extRequest = 2'b11;
  end
  // Only listed codes are ever raised
  task automatic periph_send(input logic [7:0] code, input int n);
    int t;
    for (int k = 0; k < n; k++) begin
      periphReq[code] <= 1'b1;
      t = 0;
      do @(posedge core_clk); while (periphAck[code] !== 1'b1 && ++t < 400);
      misses += (t >= 400);
      periphReq[code] <= 1'b0;
      @(posedge core_clk);
    end
  endtask : periph_send
  // Idle level first, so an edge mode sees a genuine transition
  task automatic ext_send(input int ch, input logic act, input int n);
    int t;
    extRequest[ch] <= ~act;
    repeat (4) @(posedge core_clk);
    for (int k = 0; k < n; k++) begin
      extRequest[ch] <= act;
      t = 0;
      do @(posedge core_clk); while (extAcknowledge[ch] !== 1'b1 && ++t < 200);
      misses += (t >= 200);
      extRequest[ch] <= ~act;
      repeat (4) @(posedge core_clk);
    end
  endtask : ext_send
endmodule : drsf_req_model
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the DMA request flow block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] AUTO = drsf_pkg::RS_AUTO;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [255:0] periphReq;
  logic [255:0] periphAck;
  logic [1:0] extRequest;
  logic [1:0] extAcknowledge;
  logic nmiEvent = 1'b0;
  logic addrErrorEvent = 1'b0;
  drsf_pkg::drsf_xfer_s xfer;
  logic [3:0] halfCountIrq;
  logic [3:0] completionIrq;
  logic rdPhase = 1'b0;
  int fails = 0;
  int n_tests = 0;
  int nHalf = 0;
  int nDone = 0;
  logic [31:0] rdQ[$];
  logic [7:0] xfQ[$];
  always #2.5 core_clk = ~core_clk;
  drsf_dma_request_select_flow #(.COUNT_W(24), .PERIPH_N(256)) drsf_dma_request_select_flow_inst (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .periphReq(periphReq), .periphAck(periphAck), .extRequest(extRequest), .extAcknowledge(extAcknowledge),
    .nmiEvent(nmiEvent), .addrErrorEvent(addrErrorEvent), .xfer(xfer), .halfCountIrq(halfCountIrq),
    .completionIrq(completionIrq));
  drsf_req_model #(.PERIPH_N(256)) drsf_req_model_inst (.core_clk(core_clk), .periphAck(periphAck),
    .extAcknowledge(extAcknowledge), .periphReq(periphReq), .extRequest(extRequest));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    check(32'(rdQ.size() + xfQ.size() + drsf_req_model_inst.misses), 32'h0);
    if (fails == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // Compare each result with the oldest note
  always @(posedge core_clk) begin
    if (rst_n) begin
      if (xfer.valid === 1'b1) check({24'h0, xfer}, {24'h0, (xfQ.size() > 0) ? xfQ.pop_front() : 8'h0});
      if (rdPhase && hreadyout === 1'b1) check(hrdata, (rdQ.size() > 0) ? rdQ.pop_front() : 32'hdead0bad);
      nHalf += $countones(halfCountIrq);
      nDone += $countones(completionIrq);
    end
  end
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    int t;
    t = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1 && ++t < 50);
    htrans <= 2'h0;
    hwdata <= d;
    rdPhase <= !wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1 && ++t < 50);
    rdPhase <= 1'b0;
    if (t >= 50) begin
      check(32'h0, 32'h1);
      close_out();
    end
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rdQ.push_back(exp);
    bus(a, 1'b0, 32'h0);
  endtask : rd
  // Wait for noted units, then a quiet spell
  task automatic drain();
    int t;
    t = 0;
    while (xfQ.size() != 0 && ++t < 600) @(posedge core_clk);
    if (t >= 600) begin
      check(32'h0, 32'h1);
      close_out();
    end
    repeat (20) @(posedge core_clk);
  endtask : drain
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
  endtask : do_reset
  function automatic logic [7:0] ca(input int ch, input int off);
    return 8'(8'h40 + 16 * ch + off);
  endfunction : ca
  // Control word: {ovr,edge,pol} and {half,done} enables, enable bit set
  function automatic logic [31:0] ctl(input logic [3:0] rs, input logic [1:0] sz, input logic [2:0] pe,
                                      input logic [1:0] ie);
    return {16'h0, rs, 2'h0, sz, 1'b0, pe, ie, 2'b01};
  endfunction : ctl
  function automatic logic [7:0] xv(input logic [1:0] ch, input logic [1:0] sz, input drsf_pkg::drsf_amode_e m);
    return {1'b1, ch, sz, m};
  endfunction : xv
  initial begin
    logic [31:0] r;
    logic [1:0] sz;
    void'($urandom(53579));
    do_reset();
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    r = $urandom();
    bus(8'h04, 1'b1, r);
    bus(8'h08, 1'b1, ~r);
    rd(8'h04, {16'h0, r[15:0]});
    rd(8'h08, {16'h0, ~r[15:0]});
    bus(8'hfc, 1'b1, r);
    rd(8'hfc, 32'h0);
    do_reset();
    sz = 2'($urandom_range(3, 0));
    for (int k = 0; k < 4; k++) xfQ.push_back(xv(2'h0, sz, drsf_pkg::ADDR_DUAL));
    bus(8'h00, 1'b1, 32'h1);
    bus(ca(0, 4), 1'b1, 32'd4);
    bus(ca(0, 0), 1'b1, ctl(AUTO, sz, 3'h0, 2'h3));
    drain();
    check(32'(nHalf), 32'h1);
    check(32'(nDone), 32'h1);
    rd(ca(0, 4), 32'h0);
    rd(ca(0, 8), 32'd4);
    rd(ca(0, 0), ctl(AUTO, sz, 3'h0, 2'h3) | 32'h2);
    // Flags set first; a blind write keeps them
    nmiEvent <= 1'b1;
    @(posedge core_clk);
    nmiEvent <= 1'b0;
    addrErrorEvent <= 1'b1;
    @(posedge core_clk);
    addrErrorEvent <= 1'b0;
    bus(ca(1, 4), 1'b1, 32'd2);
    bus(ca(1, 0), 1'b1, ctl(AUTO, 2'h1, 3'h0, 2'h0));
    bus(8'h00, 1'b1, 32'h1);
    rd(8'h00, 32'h7);
    for (int k = 0; k < 2; k++) xfQ.push_back(xv(2'h1, 2'h1, drsf_pkg::ADDR_DUAL));
    bus(8'h00, 1'b1, 32'h1);
    drain();
    rd(8'h00, 32'h1);
    // Selector requests wait for source 1000
    bus(8'h08, 1'b1, 32'h8281);
    for (int c = 2; c < 4; c++) begin
      automatic logic [7:0] code = 8'(8'h7f + c);
      bus(ca(c, 4), 1'b1, 32'd2);
      bus(ca(c, 0), 1'b1, ctl(drsf_pkg::RS_EXT_DUAL, 2'h2, 3'h0, 2'h0));
      fork
        drsf_req_model_inst.periph_send(code, 2);
      join_none
      repeat (20) @(posedge core_clk);
      for (int k = 0; k < 2; k++) xfQ.push_back(xv(2'(c), 2'h2, drsf_pkg::ADDR_DUAL));
      bus(ca(c, 0), 1'b1, ctl(drsf_pkg::RS_PERIPH, 2'h2, 3'h0, 2'h0));
      drain();
    end
    // External pins: rising, falling, high level overrun 0, low level overrun 1
    do_reset();
    bus(8'h00, 1'b1, 32'h1);
    for (int k = 0; k < 4; k++) begin
      automatic logic [2:0] pe = (k == 0) ? 3'b011 : (k == 1) ? 3'b010 : (k == 2) ? 3'b001 : 3'b100;
      automatic drsf_pkg::drsf_amode_e m = (k == 0) ? drsf_pkg::ADDR_MEM_TO_DEV :
                                           (k == 1) ? drsf_pkg::ADDR_DEV_TO_MEM : drsf_pkg::ADDR_DUAL;
      automatic int nReq = (k < 2) ? 2 : 1;
      bus(ca(k % 2, 4), 1'b1, 32'd16);
      bus(ca(k % 2, 0), 1'b1, ctl((k < 2) ? 4'(k + 2) : 4'h0, 2'h3, pe, 2'h0));
      for (int j = 0; j < nReq + (k == 3); j++) xfQ.push_back(xv(2'(k % 2), 2'h3, m));
      drsf_req_model_inst.ext_send(k % 2, pe[0], nReq);
      drain();
    end
    // Auto requests granted in priority order
    for (int p = 0; p < 3; p++) begin
      automatic logic [1:0] pr = (p == 2) ? 2'h3 : 2'(p);
      automatic logic [31:0] order = (p == 0) ? 32'h3210 : (p == 1) ? 32'h1320 : 32'h32103210;
      do_reset();
      bus(8'h00, 1'b1, {22'h0, pr, 8'h0});
      for (int c = 0; c < 4; c++) begin
        bus(ca(c, 4), 1'b1, (p == 2) ? 32'd2 : 32'd1);
        bus(ca(c, 0), 1'b1, ctl(AUTO, 2'(c), 3'h0, 2'h0));
      end
      for (int j = 0; j < ((p == 2) ? 8 : 4); j++) xfQ.push_back(xv(order[4*j +: 2], order[4*j +: 2], drsf_pkg::ADDR_DUAL));
      bus(8'h00, 1'b1, {22'h0, pr, 8'h1});
      drain();
    end
    close_out();
  end
endmodule : tb_top
`default_nettype wire
